//--- hdl/das_alarm_map.vh
/*
 Alarm supervisor constants: alarm codes, lamp blink counts, timing figures.
 Assumes it is included by the design files of the alarm supervisor and by its testbench only.
*/
`ifndef DAS_ALARM_MAP_VH
`define DAS_ALARM_MAP_VH

// Alarm codes
`define DAS_CODE_NONE 8'h00
`define DAS_CODE_DATA 8'h41
`define DAS_CODE_SENSOR 8'h42
`define DAS_CODE_RUNPROT 8'h46
`define DAS_CODE_EXTSTOP 8'h6E
`define DAS_CODE_LINKERR 8'h84
`define DAS_CODE_TIMEOUT 8'h85
`define DAS_CODE_CPU 8'hF0

// Lamp blinks per burst
`define DAS_BLINK_NONE 4'h0
`define DAS_BLINK_DATA 4'h8
`define DAS_BLINK_SENSOR 4'h3
`define DAS_BLINK_RUNPROT 4'hB
`define DAS_BLINK_EXTSTOP 4'hA
`define DAS_BLINK_LINK 4'hC

// Clock rate and millisecond tick
`define DAS_CLK_HZ 32'h0131_2D00
`define DAS_MS_HZ 32'h0000_03E8

// Times in milliseconds
`define DAS_SETTLE_MS 4'h2
`define DAS_BLINK_ON_MS 12'h0C8
`define DAS_BLINK_OFF_MS 12'h0C8
`define DAS_BLINK_GAP_MS 12'h4B0

// Synchronised pin positions
`define DAS_PIN_SENSOR 0
`define DAS_PIN_START 1
`define DAS_PIN_HOLD 2
`define DAS_PIN_FWD 3
`define DAS_PIN_CCW 4
`define DAS_PIN_EXT 5
`define DAS_PIN_CPU 6
`define DAS_PIN_ARST 7
`define DAS_PIN_W 8

`endif

//--- hdl/das_sync2.v
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no multi-bit coherence is promised.
*/
`timescale 1ns/10ps
module das_sync2 #(
    parameter W = 1
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;
endmodule // das_sync2

//--- hdl/das_lamp_blinker.v
/*
 Indicator lamp driver: steady on when healthy or on a steady alarm,
 otherwise bursts of N blinks separated by a dark gap.
 Assumes a one-cycle millisecond tick from the same clock.
*/
`timescale 1ns/10ps
`include "das_alarm_map.vh"
module das_lamp_blinker (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire tick_in,
    input wire alarm_in,
    input wire steady_in,
    input wire [3:0] blinks_in,
    output reg lamp_out
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ON = 4'b0010;
    localparam [3:0] ST_OFF = 4'b0100;
    localparam [3:0] ST_GAP = 4'b1000;

    reg [3:0] st_r;
    reg [11:0] t_r;
    reg [3:0] n_r;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            t_r <= 12'h000;
            n_r <= 4'h0;
            lamp_out <= 1'b0;
        end else if (!alarm_in || steady_in) begin
            st_r <= ST_IDLE;
            t_r <= 12'h000;
            n_r <= 4'h0;
            lamp_out <= 1'b1;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    st_r <= ST_GAP;
                    t_r <= 12'h000;
                    lamp_out <= 1'b0;
                end
                ST_GAP: if (tick_in) begin
                    if (t_r == `DAS_BLINK_GAP_MS - 12'h001) begin
                        st_r <= ST_ON;
                        t_r <= 12'h000;
                        n_r <= 4'h0;
                        lamp_out <= 1'b1;
                    end else begin
                        t_r <= t_r + 12'h001;
                    end
                end
                ST_ON: if (tick_in) begin
                    if (t_r == `DAS_BLINK_ON_MS - 12'h001) begin
                        st_r <= ST_OFF;
                        t_r <= 12'h000;
                        n_r <= n_r + 4'h1;
                        lamp_out <= 1'b0;
                    end else begin
                        t_r <= t_r + 12'h001;
                    end
                end
                ST_OFF: if (tick_in) begin
                    if (t_r == `DAS_BLINK_OFF_MS - 12'h001) begin
                        t_r <= 12'h000;
                        if (n_r >= blinks_in) begin
                            st_r <= ST_GAP;
                        end else begin
                            st_r <= ST_ON;
                            lamp_out <= 1'b1;
                        end
                    end else begin
                        t_r <= t_r + 12'h001;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    lamp_out <= 1'b1;
                end
            endcase
        end
    end
endmodule // das_lamp_blinker

//--- hdl/das_alarm_supervisor.v
/*
 Alarm supervisor for a motor driver: detects data, sensor, power-up run,
 external stop, serial link and processor faults, latches one alarm code,
 holds the motor and drives the indicator lamp.
 Assumes pins arrive asynchronous; config levels and link pulses come from
 logic on clk_sys_in; a power cycle is a reset on rst_n_in.
 Assumes the alarm reset pin is pressed as an edge with a low spell between
 presses, and that a limit or timeout of zero means that check is unused.
 Link timing starts at reset, so a host that never speaks still times out.
 One millisecond tick serves settle, timeout and lamp, so CYC_PER_MS
 scales all three together.
*/
`timescale 1ns/10ps
`include "das_alarm_map.vh"
module das_alarm_supervisor #(
    parameter CYC_PER_MS = `DAS_CLK_HZ / `DAS_MS_HZ,
    parameter ERR_W = 8,
    parameter TMO_W = 16
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire data_corrupt_in,
    input wire sensor_fault_in,
    input wire cpu_fault_in,
    input wire run_request_input_in,
    input wire motion_hold_select_input_in,
    input wire forward_rotation_input_in,
    input wire counter_clockwise_input_in,
    input wire external_fault_input_in,
    input wire alarm_reset_input_in,
    input wire three_wire_mode_in,
    input wire run_protect_en_in,
    input wire ext_fault_assigned_in,
    input wire host_ext_stop_in,
    input wire frame_ok_in,
    input wire frame_err_in,
    input wire [ERR_W-1:0] err_limit_in,
    input wire [TMO_W-1:0] timeout_ms_in,
    output reg alarm_active_out,
    output reg [7:0] alarm_code_out,
    output reg motor_enable_out,
    output reg [ERR_W-1:0] err_count_out,
    output wire power_fault_lamp_out
);
    localparam integer MS_LAST_I = CYC_PER_MS - 1;
    localparam [15:0] MS_LAST = MS_LAST_I[15:0];

    wire [`DAS_PIN_W-1:0] pin_raw;
    wire [`DAS_PIN_W-1:0] pin_s;
    reg arst_d_r;
    reg [15:0] ms_cnt_r;
    reg ms_tick_r;
    reg [3:0] pu_cnt_r;
    reg pu_done_r;
    reg [ERR_W-1:0] err_cnt_r;
    reg [TMO_W-1:0] tmo_cnt_r;
    reg [7:0] code_nxt;
    reg [3:0] blinks;
    reg alarm_nxt;
    reg [7:0] cand_code;

    reg [1:0] pin_vld_r;

    wire run_cmd;
    wire ext_level;
    wire pu_chk;
    wire ev_data;
    wire ev_sensor;
    wire ev_runprot;
    wire ev_ext;
    wire ev_link;
    wire ev_tmo;
    wire ev_cpu;
    wire ev_any;
    wire arst_rise;
    wire resettable;
    wire do_clear;

    wire pins_settled;
    wire ev_ext_pin;
    wire ev_ext_host;
    wire err_step;
    wire lamp_steady;

    // Every pin passes two flops before use
    // Order follows the pin positions, highest first
    assign pin_raw = {
        alarm_reset_input_in,
        cpu_fault_in,
        external_fault_input_in,
        counter_clockwise_input_in,
        forward_rotation_input_in,
        motion_hold_select_input_in,
        run_request_input_in,
        sensor_fault_in
    };

    das_sync2 #(
        .W(`DAS_PIN_W)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .d_in(pin_raw),
        .q_out(pin_s)
    );

    // Sync flops reset low and a low fault pin means a fault, so the
    // fault pin is not trusted until two edges have refilled them
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_vld_r <= 2'h0;
        end else begin
            pin_vld_r <= {pin_vld_r[0], 1'b1};
        end
    end

    assign pins_settled = pin_vld_r[1];

    // Run command decode per input scheme
    assign run_cmd = three_wire_mode_in ?
        (pin_s[`DAS_PIN_START] & pin_s[`DAS_PIN_HOLD]) :
        (pin_s[`DAS_PIN_FWD] | pin_s[`DAS_PIN_CCW]);

    // Unassigned fault input reads as on, so it never trips
    assign ext_level = ext_fault_assigned_in ? pin_s[`DAS_PIN_EXT] : 1'b1;

    // Millisecond tick shared by power-up settle, timeout and lamp
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ms_cnt_r <= 16'h0000;
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == MS_LAST) begin
            ms_cnt_r <= 16'h0000;
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r <= ms_cnt_r + 16'h0001;
            ms_tick_r <= 1'b0;
        end
    end

    // Power-up checks run once, after the pins have settled
    assign pu_chk = ms_tick_r & ~pu_done_r & (pu_cnt_r == `DAS_SETTLE_MS - 4'h1);

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pu_cnt_r <= 4'h0;
            pu_done_r <= 1'b0;
        end else if (ms_tick_r && !pu_done_r) begin
            if (pu_chk) begin
                pu_done_r <= 1'b1;
            end else begin
                pu_cnt_r <= pu_cnt_r + 4'h1;
            end
        end
    end

    // Events
    assign ev_data = data_corrupt_in;
    assign ev_sensor = pu_chk & pin_s[`DAS_PIN_SENSOR];
    assign ev_runprot = pu_chk & run_protect_en_in & run_cmd;
    assign ev_ext_pin = pins_settled & ~ext_level;
    assign ev_ext_host = host_ext_stop_in;
    assign ev_ext = ev_ext_pin | ev_ext_host;
    assign ev_link = (err_limit_in != {ERR_W{1'b0}}) & (err_cnt_r >= err_limit_in);
    assign ev_tmo = (timeout_ms_in != {TMO_W{1'b0}}) & (tmo_cnt_r >= timeout_ms_in);
    assign ev_cpu = pin_s[`DAS_PIN_CPU];
    assign ev_any = ev_data | ev_sensor | ev_runprot | ev_ext | ev_link | ev_tmo | ev_cpu;

    // Alarm reset acts on the rising edge of the synchronised input
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arst_d_r <= 1'b0;
        end else begin
            arst_d_r <= pin_s[`DAS_PIN_ARST];
        end
    end

    assign arst_rise = pin_s[`DAS_PIN_ARST] & ~arst_d_r;
    assign resettable = (alarm_code_out != `DAS_CODE_DATA) &&
                        (alarm_code_out != `DAS_CODE_CPU);
    assign do_clear = alarm_active_out & arst_rise & resettable;

    // Consecutive error run; a good frame ends the run, while an error that
    // meets an alarm reset starts a new run rather than being lost
    assign err_step = frame_err_in && (err_cnt_r != {ERR_W{1'b1}});

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_cnt_r <= {ERR_W{1'b0}};
        end else if (frame_ok_in) begin
            err_cnt_r <= {ERR_W{1'b0}};
        end else if (do_clear) begin
            err_cnt_r <= {{(ERR_W-1){1'b0}}, frame_err_in};
        end else if (err_step) begin
            err_cnt_r <= err_cnt_r + {{(ERR_W-1){1'b0}}, 1'b1};
        end
    end

    // Milliseconds since the last good frame or alarm clear, saturating
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmo_cnt_r <= {TMO_W{1'b0}};
        end else if (do_clear || frame_ok_in) begin
            tmo_cnt_r <= {TMO_W{1'b0}};
        end else if (ms_tick_r && (tmo_cnt_r != {TMO_W{1'b1}})) begin
            tmo_cnt_r <= tmo_cnt_r + {{(TMO_W-1){1'b0}}, 1'b1};
        end
    end

    // Highest-priority event present this cycle
    // Processor and stored data first, then power-up checks, then run time
    always @* begin
        if (ev_cpu) begin
            cand_code = `DAS_CODE_CPU;
        end else if (ev_data) begin
            cand_code = `DAS_CODE_DATA;
        end else if (ev_sensor) begin
            cand_code = `DAS_CODE_SENSOR;
        end else if (ev_runprot) begin
            cand_code = `DAS_CODE_RUNPROT;
        end else if (ev_ext) begin
            cand_code = `DAS_CODE_EXTSTOP;
        end else if (ev_link) begin
            cand_code = `DAS_CODE_LINKERR;
        end else if (ev_tmo) begin
            cand_code = `DAS_CODE_TIMEOUT;
        end else begin
            cand_code = `DAS_CODE_NONE;
        end
    end

    // First alarm holds its code; processor fault overrides; an event in
    // the reset cycle keeps the alarm up, so nothing is lost
    always @* begin
        alarm_nxt = alarm_active_out;
        code_nxt = alarm_code_out;
        if (!alarm_active_out) begin
            if (ev_any) begin
                alarm_nxt = 1'b1;
                code_nxt = cand_code;
            end
        end else if (ev_cpu) begin
            code_nxt = `DAS_CODE_CPU;
        end else if (do_clear) begin
            if (ev_any) begin
                code_nxt = cand_code;
            end else begin
                alarm_nxt = 1'b0;
                code_nxt = `DAS_CODE_NONE;
            end
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alarm_active_out <= 1'b0;
            alarm_code_out <= `DAS_CODE_NONE;
            motor_enable_out <= 1'b0;
            err_count_out <= {ERR_W{1'b0}};
        end else begin
            alarm_active_out <= alarm_nxt;
            alarm_code_out <= code_nxt;
            // Motor waits for the power-up checks and any pending alarm
            motor_enable_out <= pu_done_r & ~alarm_nxt;
            // Copy lags the live count by one edge
            err_count_out <= err_cnt_r;
        end
    end

    // Blink count per latched code
    always @* begin
        case (alarm_code_out)
            `DAS_CODE_DATA: blinks = `DAS_BLINK_DATA;
            `DAS_CODE_SENSOR: blinks = `DAS_BLINK_SENSOR;
            `DAS_CODE_RUNPROT: blinks = `DAS_BLINK_RUNPROT;
            `DAS_CODE_EXTSTOP: blinks = `DAS_BLINK_EXTSTOP;
            `DAS_CODE_LINKERR: blinks = `DAS_BLINK_LINK;
            `DAS_CODE_TIMEOUT: blinks = `DAS_BLINK_LINK;
            default: blinks = `DAS_BLINK_NONE;
        endcase
    end

    assign lamp_steady = (alarm_code_out == `DAS_CODE_CPU);

    das_lamp_blinker u_lamp (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .tick_in(ms_tick_r),
        .alarm_in(alarm_active_out),
        .steady_in(lamp_steady),
        .blinks_in(blinks),
        .lamp_out(power_fault_lamp_out)
    );
endmodule // das_alarm_supervisor

//--- test/das_alarm_properties.sv
/* Port checker for the alarm supervisor.
   Assumes a bind onto das_alarm_supervisor and a single clock domain. */
`timescale 1ns/10ps
module das_alarm_properties #(
    parameter ERR_W = 8,
    parameter TMO_W = 16
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire data_corrupt_in,
    input wire sensor_fault_in,
    input wire cpu_fault_in,
    input wire run_request_input_in,
    input wire motion_hold_select_input_in,
    input wire forward_rotation_input_in,
    input wire counter_clockwise_input_in,
    input wire external_fault_input_in,
    input wire alarm_reset_input_in,
    input wire three_wire_mode_in,
    input wire run_protect_en_in,
    input wire ext_fault_assigned_in,
    input wire host_ext_stop_in,
    input wire frame_ok_in,
    input wire frame_err_in,
    input wire [ERR_W-1:0] err_limit_in,
    input wire [TMO_W-1:0] timeout_ms_in,
    input wire alarm_active_out,
    input wire [7:0] alarm_code_out,
    input wire motor_enable_out,
    input wire [ERR_W-1:0] err_count_out,
    input wire power_fault_lamp_out
);
    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // Four samples cover the two sync stages whatever the pin phase
    sequence cpu_seen;
        cpu_fault_in [*4];
    endsequence
    sequence ext_low_seen;
        (ext_fault_assigned_in && !external_fault_input_in) [*4];
    endsequence
    // Two samples skip the lagging count copy right after a clear
    sequence err_full;
        (err_limit_in != 0 && err_count_out >= err_limit_in) [*2];
    endsequence
    motor_off_a: assert property (alarm_active_out |-> !motor_enable_out)
        else $error("motor enabled in alarm");
    cpu_entry_a: assert property (cpu_seen |-> ##[0:2] alarm_code_out == 8'hF0)
        else $error("processor fault not latched");
    cpu_hold_a: assert property (alarm_code_out == 8'hF0 |=> alarm_code_out == 8'hF0)
        else $error("processor alarm cleared");
    cpu_lamp_a: assert property (alarm_code_out == 8'hF0 [*3] |-> power_fault_lamp_out)
        else $error("lamp not steady on processor alarm");
    data_hold_a: assert property (alarm_code_out == 8'h41 |=> alarm_active_out
        && alarm_code_out inside {8'h41, 8'hF0}) else $error("data alarm cleared");
    clear_ok_a: assert property ($fell(alarm_active_out) |-> alarm_code_out == 8'h00
        && !($past(alarm_code_out) inside {8'h41, 8'hF0})) else $error("bad clear");
    ext_stop_a: assert property (ext_low_seen |-> ##[0:2] alarm_active_out)
        else $error("external fault ignored");
    host_stop_a: assert property (host_ext_stop_in |-> ##[1:2] alarm_active_out)
        else $error("host stop ignored");
    err_zero_a: assert property (frame_ok_in && !frame_err_in |-> ##[1:3] err_count_out == 0)
        else $error("error count not cleared");
    err_alarm_a: assert property (err_full |-> ##[0:2] alarm_active_out)
        else $error("error limit ignored");
endmodule // das_alarm_properties

//--- test/das_host_model.sv
/* Host controller model: frame results and stop commands on the link.
   Assumes the supervisor clock; every pulse lasts one cycle. */
`timescale 1ns/10ps
module das_host_model (
    input wire clk_sys_in,
    output logic frame_ok_out,
    output logic frame_err_out,
    output logic ext_stop_out
);
    initial begin
        frame_ok_out = 1'b0;
        frame_err_out = 1'b0;
        ext_stop_out = 1'b0;
    end
    // Gap lets the host answer promptly or slowly
    task automatic send(input logic ok, input int gap);
        @(posedge clk_sys_in);
        frame_ok_out <= ok;
        frame_err_out <= !ok;
        @(posedge clk_sys_in);
        frame_ok_out <= 1'b0;
        frame_err_out <= 1'b0;
        repeat (gap) @(posedge clk_sys_in);
    endtask
    task automatic ext_stop();
        @(posedge clk_sys_in);
        ext_stop_out <= 1'b1;
        @(posedge clk_sys_in);
        ext_stop_out <= 1'b0;
    endtask
    // Data alarm recovery is a power cycle by the bench
endmodule // das_host_model

//--- test/testbench.sv
/* Self-checking bench for the alarm supervisor with a host link model.
   Assumes a millisecond scaled down to four clock cycles. */
`timescale 1ns/10ps
`include "das_alarm_map.vh"
module testbench;
    localparam int MS = 4;
    logic clk_sys_in, rst_n_in, data_corrupt_in, sensor_fault_in, cpu_fault_in;
    logic run_request_input_in, motion_hold_select_input_in, forward_rotation_input_in;
    logic counter_clockwise_input_in, external_fault_input_in, alarm_reset_input_in;
    logic three_wire_mode_in, run_protect_en_in, ext_fault_assigned_in;
    logic [7:0] err_limit_in;
    logic [15:0] timeout_ms_in;
    wire frame_ok_in, frame_err_in, host_ext_stop_in;
    wire alarm_active_out, motor_enable_out, power_fault_lamp_out;
    wire [7:0] alarm_code_out, err_count_out;
    int error_cnt = 0;
    int n_compared = 0;
    int i, m;
    logic exp_run;
    always #25 clk_sys_in = ~clk_sys_in;
    das_alarm_supervisor #(.CYC_PER_MS(MS)) u_dut (.*);
    das_host_model u_host (.clk_sys_in(clk_sys_in), .frame_ok_out(frame_ok_in),
        .frame_err_out(frame_err_in), .ext_stop_out(host_ext_stop_in));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // Samples just after the edge, then realigns to the next edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
        tick(1);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_alarm();
        int k;
        k = 0;
        #1;
        while (alarm_active_out !== 1'b1 && k < 200) begin
            @(posedge clk_sys_in);
            #1;
            k++;
        end
        @(posedge clk_sys_in);
        if (k == 200) begin
            error_cnt++;
            $display("MISMATCH %0t alarm missing", $time);
            end_sim();
        end
    endtask
    task automatic press();
        tick(3);
        alarm_reset_input_in <= 1'b1;
        tick(4);
        alarm_reset_input_in <= 1'b0;
        tick(6);
    endtask
    task automatic power();
        rst_n_in <= 1'b0;
        tick(2);
        rst_n_in <= 1'b1;
        tick(40);
    endtask
    // Counts lamp rises over one dark gap plus one burst
    task automatic blinks(input int n);
        int r;
        logic prev;
        r = 0;
        prev = power_fault_lamp_out;
        repeat ((`DAS_BLINK_GAP_MS + n * (`DAS_BLINK_ON_MS + `DAS_BLINK_OFF_MS)) * MS) begin
            @(posedge clk_sys_in);
            #1;
            if (power_fault_lamp_out === 1'b1 && prev === 1'b0) begin
                r++;
            end
            prev = power_fault_lamp_out;
        end
        chk(8'(r), 8'(n));
    endtask
    initial begin
        {clk_sys_in, rst_n_in, data_corrupt_in, sensor_fault_in, cpu_fault_in} = 5'h00;
        {run_request_input_in, motion_hold_select_input_in, forward_rotation_input_in} = 3'h0;
        {counter_clockwise_input_in, alarm_reset_input_in, three_wire_mode_in} = 3'h0;
        {run_protect_en_in, external_fault_input_in, ext_fault_assigned_in} = 3'h3;
        err_limit_in = 8'h00;
        timeout_ms_in = 16'h0000;
        tick(20);
        rst_n_in <= 1'b1;
        tick(40);
        chk(alarm_code_out, 8'h00);
        chk(8'(motor_enable_out), 8'h01);
        chk(8'(power_fault_lamp_out), 8'h01);
        u_host.ext_stop();
        wait_alarm();
        chk(alarm_code_out, 8'h6E);
        press();
        chk(8'(alarm_active_out), 8'h00);
        external_fault_input_in <= 1'b0;
        wait_alarm();
        chk(alarm_code_out, 8'h6E);
        chk(8'(motor_enable_out), 8'h00);
        external_fault_input_in <= 1'b1;
        press();
        chk(8'(alarm_active_out), 8'h00);
        ext_fault_assigned_in <= 1'b0;
        external_fault_input_in <= 1'b0;
        tick(20);
        chk(8'(alarm_active_out), 8'h00);
        // Pin first: it lags the config level by two sync stages
        external_fault_input_in <= 1'b1;
        tick(4);
        ext_fault_assigned_in <= 1'b1;
        err_limit_in <= 8'h03;
        u_host.send(1'b0, 2);
        u_host.send(1'b0, 0);
        u_host.send(1'b1, 3);
        u_host.send(1'b0, 1);
        u_host.send(1'b0, 4);
        chk(8'(alarm_active_out), 8'h00);
        chk(err_count_out, 8'h02);
        u_host.send(1'b0, 0);
        wait_alarm();
        chk(alarm_code_out, 8'h84);
        err_limit_in <= 8'h00;
        press();
        chk(err_count_out, 8'h00);
        u_host.send(1'b1, 0);
        timeout_ms_in <= 16'h0003;
        tick(4);
        chk(8'(alarm_active_out), 8'h00);
        wait_alarm();
        chk(alarm_code_out, 8'h85);
        timeout_ms_in <= 16'h0000;
        press();
        data_corrupt_in <= 1'b1;
        wait_alarm();
        chk(alarm_code_out, 8'h41);
        blinks(8);
        data_corrupt_in <= 1'b0;
        press();
        chk(alarm_code_out, 8'h41);
        power();
        chk(alarm_code_out, 8'h00);
        cpu_fault_in <= 1'b1;
        wait_alarm();
        chk(alarm_code_out, 8'hF0);
        // Fault gone before the press, so only the refusal keeps the alarm
        cpu_fault_in <= 1'b0;
        press();
        for (i = 0; i < 60; i++) begin
            chk(8'(power_fault_lamp_out), 8'h01);
            tick(100);
        end
        chk(alarm_code_out, 8'hF0);
        sensor_fault_in <= 1'b1;
        power();
        wait_alarm();
        chk(alarm_code_out, 8'h42);
        blinks(3);
        sensor_fault_in <= 1'b0;
        press();
        chk(8'(alarm_active_out), 8'h00);
        // Inputs of the unused scheme stay on to catch a crossed decode
        run_protect_en_in <= 1'b1;
        for (m = 0; m < 2; m++) begin
            for (i = 0; i < 4; i++) begin
                three_wire_mode_in <= m[0];
                {run_request_input_in, motion_hold_select_input_in} <= m ? i[1:0] : 2'h3;
                {forward_rotation_input_in, counter_clockwise_input_in} <= m ? 2'h3 : i[1:0];
                exp_run = m ? (i == 3) : (i != 0);
                power();
                chk(alarm_code_out, exp_run ? 8'h46 : 8'h00);
                press();
                chk(8'(alarm_active_out), 8'h00);
            end
        end
        end_sim();
    end
endmodule // testbench
bind das_alarm_supervisor das_alarm_properties #(.ERR_W(ERR_W), .TMO_W(TMO_W)) u_props (.*);
